/* core/csr_pkg.sv */
// constants, types and field layout for the core special-register block
// assumes the execution unit presents one register access per cycle
package csr_pkg;
   // special register addresses within sector 0 (own map; direct address low byte)
   localparam logic [7:0] CSR_A_PORT0 = 8'h00;
   localparam logic [7:0] CSR_A_PTR0 = 8'h01;
   localparam logic [7:0] CSR_A_PORT1 = 8'h02;
   localparam logic [7:0] CSR_A_PTR1L = 8'h03;
   localparam logic [7:0] CSR_A_PTR1H = 8'h04;
   localparam logic [7:0] CSR_A_ACC = 8'h05;
   localparam logic [7:0] CSR_A_PCLOW = 8'h06;
   localparam logic [7:0] CSR_A_TBLLOW = 8'h07;
   localparam logic [7:0] CSR_A_TBLHIGH = 8'h08;
   localparam logic [7:0] CSR_A_TBHLATCH = 8'h09;
   localparam logic [7:0] CSR_A_STATUS = 8'h0A;
   localparam logic [7:0] CSR_A_BANK = 8'h0B;
   localparam logic [7:0] CSR_A_PORT2 = 8'h0C;
   localparam logic [7:0] CSR_A_PTR2L = 8'h0D;
   localparam logic [7:0] CSR_A_PTR2H = 8'h0E;
   // sector field width of a full data address
   localparam int CSR_SEC_W = 1;
   localparam logic [CSR_SEC_W-1:0] CSR_SEC_ZERO = 1'h0;
   // status bit positions
   localparam int CSR_B_WRAP = 0;
   localparam int CSR_B_NIB = 1;
   localparam int CSR_B_NIL = 2;
   localparam int CSR_B_SWRAP = 3;
   localparam int CSR_B_HALT = 4;
   localparam int CSR_B_DOG = 5;
   localparam int CSR_B_CNIL = 6;
   localparam int CSR_B_SXOR = 7;
   localparam logic [7:0] CSR_STATUS_RST = 8'h00;
   localparam logic [7:0] CSR_STATUS_RO = 8'h30;
   localparam logic [7:0] CSR_BANK_MASK = 8'h01;
   localparam logic [7:0] CSR_ZERO = 8'h00;
   localparam logic [7:0] CSR_MSB_MASK = 8'h80;
   localparam logic [4:0] CSR_NIB_LIM = 5'h10;
   // alu operation kinds reported by the execution unit
   typedef enum logic [2:0] {
      CSR_OP_NONE = 3'b000,
      CSR_OP_ADD = 3'b001,
      CSR_OP_SUB = 3'b010,
      CSR_OP_SBC = 3'b011,
      CSR_OP_LOGIC = 3'b100,
      CSR_OP_ROT = 3'b101,
      CSR_OP_ADC = 3'b110
   } csr_op_t;
   // pointer step requests
   typedef enum logic [1:0] {
      CSR_STEP_NONE = 2'b00,
      CSR_STEP_INC = 2'b01,
      CSR_STEP_DEC = 2'b10
   } csr_step_t;
   // all block state
   typedef struct packed {
      logic [7:0] ptr0;
      logic [7:0] ptr1l;
      logic [CSR_SEC_W-1:0] ptr1h;
      logic [7:0] ptr2l;
      logic [CSR_SEC_W-1:0] ptr2h;
      logic bank;
      logic [7:0] tbl_low;
      logic [7:0] tbl_high;
      logic [7:0] tbh_latch;
      logic [7:0] status;
      logic [7:0] rdata;
      logic dummy;
   } csr_state_t;
endpackage

/* core/csr_core_regs.sv */
// core special registers: pointers, indirect ports, bank, table, status
// assumes the execution unit drives one access per cycle and owns data memory
`timescale 1ns/1ps
module csr_core_regs
   import csr_pkg::*;
(
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // register access from execution unit
   input wire logic acc_rd_i,
   input wire logic acc_wr_i,
   input wire logic acc_ext_i,
   input wire logic [CSR_SEC_W+7:0] acc_addr_i,
   input wire logic [7:0] acc_wdata_i,
   output logic [7:0] acc_rdata_o,
   // data memory side
   output logic mem_sel_o,
   output logic [CSR_SEC_W+7:0] mem_addr_o,
   // pointer step from inc/dec instructions
   input wire logic [1:0] step_i,
   // alu result for flag update
   input wire logic [2:0] op_i,
   input wire logic [7:0] op_a_i,
   input wire logic [7:0] op_b_i,
   input wire logic [7:0] res_i,
   input wire logic rot_c_i,
   // system events
   input wire logic wdt_clr_i,
   input wire logic halt_i,
   input wire logic wdt_tmo_i,
   // table read
   input wire logic tbl_rd_i,
   input wire logic [15:0] tbl_word_i,
   output logic [15:0] tbl_addr_o,
   // branch control
   output logic bank_o,
   output logic pc_load_o,
   output logic [7:0] pc_low_o,
   output logic dummy_o
);
   csr_state_t st_reg;
   csr_state_t st_next;
   csr_op_t op;
   logic [CSR_SEC_W+7:0] eff_addr;
   logic indirect;
   logic dir_wr;
   logic [8:0] sum9;
   logic [4:0] nib5;
   logic c7;
   logic swrap;
   logic nil;

   assign op = csr_op_t'(op_i);

   // true when low byte names one of the three indirect ports
   function automatic logic is_port(input logic [7:0] a);
      is_port = (a == CSR_A_PORT0) || (a == CSR_A_PORT1) || (a == CSR_A_PORT2);
   endfunction

   // effective address resolution
   always_comb begin
      indirect = 1'b0;
      eff_addr = acc_addr_i;
      if (acc_ext_i) begin
         eff_addr = acc_addr_i;
      end else if (acc_addr_i[7:0] == CSR_A_PORT0) begin
         indirect = 1'b1;
         eff_addr = {CSR_SEC_ZERO, st_reg.ptr0};
      end else if (acc_addr_i[7:0] == CSR_A_PORT1) begin
         indirect = 1'b1;
         eff_addr = {st_reg.ptr1h, st_reg.ptr1l};
      end else if (acc_addr_i[7:0] == CSR_A_PORT2) begin
         indirect = 1'b1;
         eff_addr = {st_reg.ptr2h, st_reg.ptr2l};
      end else begin
         eff_addr = {CSR_SEC_ZERO, acc_addr_i[7:0]};
      end
   end

   // memory access goes out for indirect or extended accesses
   assign mem_sel_o = (acc_rd_i || acc_wr_i) && (indirect || acc_ext_i);
   assign mem_addr_o = eff_addr;
   // a direct write lands in this block only when not redirected
   assign dir_wr = acc_wr_i && !indirect && !acc_ext_i;

   // arithmetic helpers for flag generation
   always_comb begin
      sum9 = 9'h000;
      nib5 = 5'h00;
      c7 = 1'b0;
      case (op)
         CSR_OP_ADD, CSR_OP_ADC: begin
            sum9 = {1'b0, op_a_i} + {1'b0, op_b_i} + {8'h00, (op == CSR_OP_ADC) &
                   st_reg.status[CSR_B_WRAP]};
            nib5 = {1'b0, op_a_i[3:0]} + {1'b0, op_b_i[3:0]} +
                   {4'h0, (op == CSR_OP_ADC) & st_reg.status[CSR_B_WRAP]};
            c7 = sum9[8] ^ op_a_i[7] ^ op_b_i[7] ^ res_i[7] ^ sum9[8];
         end
         CSR_OP_SUB, CSR_OP_SBC: begin
            // subtraction as a + ~b + carry, so carry out means no borrow
            sum9 = {1'b0, op_a_i} + {1'b0, ~op_b_i} + {8'h00, (op == CSR_OP_SUB) |
                   st_reg.status[CSR_B_WRAP]};
            nib5 = {1'b0, op_a_i[3:0]} + {1'b0, ~op_b_i[3:0]} +
                   {4'h0, (op == CSR_OP_SUB) | st_reg.status[CSR_B_WRAP]};
            c7 = op_a_i[7] ^ ~op_b_i[7] ^ res_i[7];
         end
         default: begin
            sum9 = 9'h000;
         end
      endcase
      swrap = c7 ^ sum9[8];
      nil = (res_i == CSR_ZERO);
   end

   // next-state logic
   always_comb begin
      st_next = st_reg;
      st_next.dummy = 1'b0;
      if (step_i == CSR_STEP_INC) begin
         st_next.ptr0 = st_reg.ptr0 + 8'h01;
      end else if (step_i == CSR_STEP_DEC) begin
         st_next.ptr0 = st_reg.ptr0 - 8'h01;
      end
      // flag updates from the alu
      case (op)
         CSR_OP_ADD, CSR_OP_ADC, CSR_OP_SUB, CSR_OP_SBC: begin
            st_next.status[CSR_B_WRAP] = sum9[8];
            st_next.status[CSR_B_NIB] = nib5 >= CSR_NIB_LIM;
            st_next.status[CSR_B_NIL] = nil;
            st_next.status[CSR_B_SWRAP] = swrap;
            st_next.status[CSR_B_SXOR] = swrap ^ res_i[7];
            if (op == CSR_OP_SUB) begin
               st_next.status[CSR_B_CNIL] = nil;
            end else if (op == CSR_OP_SBC) begin
               st_next.status[CSR_B_CNIL] = st_reg.status[CSR_B_CNIL] & nil;
            end
         end
         CSR_OP_LOGIC: begin
            st_next.status[CSR_B_NIL] = nil;
         end
         CSR_OP_ROT: begin
            st_next.status[CSR_B_WRAP] = rot_c_i;
         end
         default: begin
            st_next.status = st_next.status;
         end
      endcase
      // direct register writes; ports have no storage
      if (dir_wr) begin
         case (acc_addr_i[7:0])
            CSR_A_PTR0: st_next.ptr0 = acc_wdata_i;
            CSR_A_PTR1L: st_next.ptr1l = acc_wdata_i;
            CSR_A_PTR1H: st_next.ptr1h = acc_wdata_i[CSR_SEC_W-1:0];
            CSR_A_PTR2L: st_next.ptr2l = acc_wdata_i;
            CSR_A_PTR2H: st_next.ptr2h = acc_wdata_i[CSR_SEC_W-1:0];
            CSR_A_BANK: st_next.bank = acc_wdata_i[0];
            CSR_A_TBLLOW: st_next.tbl_low = acc_wdata_i;
            CSR_A_TBLHIGH: st_next.tbl_high = acc_wdata_i;
            CSR_A_TBHLATCH: st_next.tbh_latch = acc_wdata_i;
            CSR_A_STATUS: st_next.status = (acc_wdata_i & ~CSR_STATUS_RO) |
                                           (st_reg.status & CSR_STATUS_RO);
            CSR_A_PCLOW: st_next.dummy = 1'b1;
            default: st_next.dummy = st_next.dummy;
         endcase
      end
      if (tbl_rd_i) begin
         st_next.tbh_latch = tbl_word_i[15:8];
      end
      if (wdt_clr_i) begin
         st_next.status[CSR_B_HALT] = 1'b0;
      end else if (halt_i) begin
         st_next.status[CSR_B_HALT] = 1'b1;
      end
      // expiry: time-out set wins over a clear in the same cycle
      if (wdt_tmo_i) begin
         st_next.status[CSR_B_DOG] = 1'b1;
      end else if (wdt_clr_i || halt_i) begin
         st_next.status[CSR_B_DOG] = 1'b0;
      end
      // read data; ports read zero, low byte of table word on table read
      st_next.rdata = CSR_ZERO;
      if (tbl_rd_i) begin
         st_next.rdata = tbl_word_i[7:0];
      end else if (acc_rd_i && !acc_ext_i && !is_port(acc_addr_i[7:0])) begin
         case (acc_addr_i[7:0])
            CSR_A_PTR0: st_next.rdata = st_reg.ptr0;
            CSR_A_PTR1L: st_next.rdata = st_reg.ptr1l;
            CSR_A_PTR1H: st_next.rdata = {{(8-CSR_SEC_W){1'b0}}, st_reg.ptr1h};
            CSR_A_PTR2L: st_next.rdata = st_reg.ptr2l;
            CSR_A_PTR2H: st_next.rdata = {{(8-CSR_SEC_W){1'b0}}, st_reg.ptr2h};
            CSR_A_BANK: st_next.rdata = {7'h00, st_reg.bank} & CSR_BANK_MASK;
            CSR_A_TBLLOW: st_next.rdata = st_reg.tbl_low;
            CSR_A_TBLHIGH: st_next.rdata = st_reg.tbl_high;
            CSR_A_TBHLATCH: st_next.rdata = st_reg.tbh_latch;
            CSR_A_STATUS: st_next.rdata = st_reg.status;
            default: st_next.rdata = CSR_ZERO;
         endcase
      end
   end

   // state register; high pointer bytes clear at reset
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   // no stack path
   // outputs; status never leaves toward the stack, software saves it
   assign acc_rdata_o = st_reg.rdata;
   assign tbl_addr_o = {st_reg.tbl_high, st_reg.tbl_low};
   assign bank_o = st_reg.bank;
   // load only the low byte, page unchanged
   assign pc_load_o = dir_wr && (acc_addr_i[7:0] == CSR_A_PCLOW);
   assign pc_low_o = acc_wdata_i;
   assign dummy_o = st_reg.dummy;

   // checks
   port_read_zero_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      acc_rd_i && !acc_ext_i && !tbl_rd_i && is_port(acc_addr_i[7:0]) |=> acc_rdata_o == 8'h00)
      else $error("indirect port direct read not zero");
   port_redirect_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      acc_wr_i && !acc_ext_i && acc_addr_i[7:0] == CSR_A_PORT1 |->
      mem_sel_o && mem_addr_o == {st_reg.ptr1h, st_reg.ptr1l})
      else $error("port one not redirected to pointer");
   port0_sector_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      mem_sel_o && !acc_ext_i && acc_addr_i[7:0] == CSR_A_PORT0 |->
      mem_addr_o[CSR_SEC_W+7:8] == '0)
      else $error("port zero left sector 0");
   ext_addr_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      acc_ext_i && acc_rd_i |-> mem_sel_o && mem_addr_o == acc_addr_i)
      else $error("extended address altered");
   pc_dummy_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      pc_load_o |=> dummy_o ##1 (!dummy_o || $past(pc_load_o)))
      else $error("dummy cycle missing after counter write");
   tbl_latch_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      tbl_rd_i |=> st_reg.tbh_latch == $past(tbl_word_i[15:8]) &&
      acc_rdata_o == $past(tbl_word_i[7:0]))
      else $error("table read bytes wrong");
   status_ro_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      dir_wr && acc_addr_i[7:0] == CSR_A_STATUS && !wdt_clr_i && !halt_i && !wdt_tmo_i
      |=> st_reg.status[5:4] == $past(st_reg.status[5:4]))
      else $error("status write touched read-only bits");
   dog_set_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      wdt_tmo_i |=> st_reg.status[CSR_B_DOG])
      else $error("expiry bit not set on time-out");
   halt_set_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      halt_i && !wdt_clr_i |=> st_reg.status[CSR_B_HALT] &&
      ($past(wdt_tmo_i) || !st_reg.status[CSR_B_DOG]))
      else $error("halt did not set halted bit");
   nil_flag_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      op_i == CSR_OP_LOGIC |=> st_reg.status[CSR_B_NIL] == ($past(res_i) == 8'h00))
      else $error("result-nil bit wrong");
   sxor_flag_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      op_i == CSR_OP_SUB |=> st_reg.status[CSR_B_SXOR] ==
      (st_reg.status[CSR_B_SWRAP] ^ $past(res_i[7])))
      else $error("sign-xor bit wrong");
   cnil_flag_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      op_i == CSR_OP_SBC |=> st_reg.status[CSR_B_CNIL] ==
      ($past(st_reg.status[CSR_B_CNIL]) && $past(res_i) == 8'h00))
      else $error("chained-nil bit wrong");
   ptr_wrap_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      step_i == CSR_STEP_INC && !dir_wr && st_reg.ptr0 == 8'hFF |=> st_reg.ptr0 == 8'h00)
      else $error("pointer did not wrap");
   bank_zero_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      acc_rd_i && !acc_ext_i && !tbl_rd_i && acc_addr_i[7:0] == CSR_A_BANK |=>
      acc_rdata_o[7:1] == 7'h00)
      else $error("bank register upper bits not zero");
   // flag checks against plain arithmetic, not against the flag logic above, except cnil_sub_a, which compares with the result-nil bit
   wrap_add_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      op_i == CSR_OP_ADD && !dir_wr |=>
      st_reg.status[CSR_B_WRAP] == ($past(res_i) < $past(op_a_i)))
      else $error("wrap-out bit wrong after add");
   rot_carry_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      op_i == CSR_OP_ROT && !dir_wr |=> st_reg.status[CSR_B_WRAP] == $past(rot_c_i))
      else $error("wrap-out bit not loaded by rotate");
   nib_add_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      op_i == CSR_OP_ADD && !dir_wr |=>
      st_reg.status[CSR_B_NIB] == ($past(res_i[3:0]) < $past(op_a_i[3:0])))
      else $error("nibble-wrap bit wrong after add");
   swrap_add_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      op_i == CSR_OP_ADD && !dir_wr |=> st_reg.status[CSR_B_SWRAP] ==
      ($past(op_a_i[7]) == $past(op_b_i[7]) && $past(res_i[7]) != $past(op_a_i[7])))
      else $error("signed-wrap bit wrong after add");
   cnil_sub_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      op_i == CSR_OP_SUB && !dir_wr |=>
      st_reg.status[CSR_B_CNIL] == st_reg.status[CSR_B_NIL])
      else $error("chained-nil bit differs from nil on subtract");
   cnil_keep_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (op_i == CSR_OP_ADD || op_i == CSR_OP_LOGIC) && !dir_wr |=>
      $stable(st_reg.status[CSR_B_CNIL]))
      else $error("chained-nil bit changed by another op");
   halt_clr_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      wdt_clr_i |=> !st_reg.status[CSR_B_HALT])
      else $error("watchdog clear left halted bit set");
   dog_clr_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (wdt_clr_i || halt_i) && !wdt_tmo_i |=> !st_reg.status[CSR_B_DOG])
      else $error("expiry bit not cleared");
   bank_follow_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      dir_wr && acc_addr_i[7:0] == CSR_A_BANK |=> bank_o == $past(acc_wdata_i[0]))
      else $error("bank bit did not follow write");
   port_keep_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      acc_wr_i && !acc_ext_i && is_port(acc_addr_i[7:0]) && step_i == CSR_STEP_NONE |=>
      $stable({st_reg.ptr0, st_reg.ptr1l, st_reg.ptr1h, st_reg.ptr2l, st_reg.ptr2h,
      st_reg.bank}))
      else $error("indirect port write changed a register");
   port0_redirect_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (acc_rd_i || acc_wr_i) && !acc_ext_i && acc_addr_i[7:0] == CSR_A_PORT0 |->
      mem_sel_o && mem_addr_o == {CSR_SEC_ZERO, st_reg.ptr0})
      else $error("port zero not redirected to pointer");
   port2_sector_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (acc_rd_i || acc_wr_i) && !acc_ext_i && acc_addr_i[7:0] == CSR_A_PORT2 |->
      mem_sel_o && mem_addr_o == {st_reg.ptr2h, st_reg.ptr2l})
      else $error("port two sector not taken from high byte");
   ext_wr_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      acc_ext_i && acc_wr_i |-> mem_sel_o && mem_addr_o == acc_addr_i && !pc_load_o)
      else $error("extended write altered or leaked");
   ptr_dec_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      step_i == CSR_STEP_DEC && !dir_wr && st_reg.ptr0 == 8'h00 |=> st_reg.ptr0 == 8'hFF)
      else $error("pointer did not wrap downward");
   cov_ext_c: cover property (@(posedge clk_i) disable iff (!rst_n_i) acc_ext_i && acc_wr_i);
   cov_pc_c: cover property (@(posedge clk_i) disable iff (!rst_n_i) pc_load_o ##1 dummy_o);
   cov_tbl_c: cover property (@(posedge clk_i) disable iff (!rst_n_i) tbl_rd_i);
   cov_dog_c: cover property (@(posedge clk_i) disable iff (!rst_n_i)
      wdt_tmo_i ##1 wdt_clr_i);
   cov_port2_c: cover property (@(posedge clk_i) disable iff (!rst_n_i)
      mem_sel_o && acc_addr_i[7:0] == CSR_A_PORT2);
endmodule

/* verification/csr_exec_model.sv */
// far-side model: the execution unit's alu result and the program memory words
// assumes operands are held for the whole cycle in which op_i is raised
`timescale 1ns/1ps
module csr_exec_model
   import csr_pkg::*;
(
   // alu side
   input wire logic [2:0] op_i,
   input wire logic [7:0] a_i,
   input wire logic [7:0] b_i,
   input wire logic cin_i,
   output logic [7:0] res_o,
   output logic rc_o,
   // program memory side
   input wire logic [15:0] taddr_i,
   output logic [15:0] word_o
);
   // alu result; adc and borrow-subtract take the carry held in status
   always_comb begin
      case (op_i)
         CSR_OP_ADD: res_o = a_i + b_i;
         CSR_OP_ADC: res_o = a_i + b_i + 8'(cin_i);
         CSR_OP_SUB: res_o = a_i - b_i;
         CSR_OP_SBC: res_o = a_i + ~b_i + 8'(cin_i);
         CSR_OP_LOGIC: res_o = a_i & b_i;
         CSR_OP_ROT: res_o = {a_i[6:0], cin_i};
         default: res_o = 8'h00;
      endcase
   end
   // rotate left through carry: the old msb becomes the new carry
   assign rc_o = a_i[7];
   // words follow an address pattern so two reads never look alike
   assign word_o = {taddr_i[7:0] ^ 8'h5A, taddr_i[15:8] ^ 8'hC3};
endmodule

/* verification/csr_core_regs_tb_top.sv */
// self-checking bench for the core special registers
// assumes one access per cycle, inputs driven on the falling clock edge
`timescale 1ns/1ps
module csr_core_regs_tb_top
   import csr_pkg::*;
;
   logic clk_i = 0, rst_n_i = 0, acc_rd_i = 0, acc_wr_i = 0, acc_ext_i = 0;
   logic [8:0] acc_addr_i = 0;
   logic [7:0] acc_wdata_i = 0, op_a_i = 0, op_b_i = 0, res_i, acc_rdata_o, pc_low_o;
   logic [1:0] step_i = 0;
   logic [2:0] op_i = 0;
   logic rot_c_i, wdt_clr_i = 0, halt_i = 0, wdt_tmo_i = 0, tbl_rd_i = 0;
   logic mem_sel_o, bank_o, pc_load_o, dummy_o;
   logic [8:0] mem_addr_o;
   logic [15:0] tbl_word_i, tbl_addr_o;
   logic [7:0] q, pv, est = 0;
   logic [8:0] m;
   logic s, pl;
   int num_errors = 0, check_count = 0, cyc = 0;
   logic [26:0] tab [11] = '{{CSR_OP_ADD, 8'h0F, 8'h01, 8'hFF}, {CSR_OP_ADD, 8'h80, 8'h80, 8'hFF},
      {CSR_OP_ADD, 8'h7F, 8'h01, 8'hFF}, {CSR_OP_SUB, 8'h05, 8'h05, 8'hFF},
      {CSR_OP_SBC, 8'h00, 8'h00, 8'hFF}, {CSR_OP_SUB, 8'h03, 8'h05, 8'hFF},
      {CSR_OP_SBC, 8'h05, 8'h04, 8'hFF}, {CSR_OP_ADC, 8'h01, 8'h01, 8'hFF},
      {CSR_OP_SUB, 8'h80, 8'h01, 8'hFF}, {CSR_OP_LOGIC, 8'hF0, 8'h0F, 8'h74},
      {CSR_OP_ROT, 8'h81, 8'h00, 8'h71}};
   logic [8:0] pexp [3] = '{9'h055, 9'h140, 9'h07E};
   logic [7:0] padr [3] = '{CSR_A_PORT0, CSR_A_PORT1, CSR_A_PORT2};

   csr_core_regs dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .acc_rd_i(acc_rd_i), .acc_wr_i(acc_wr_i),
      .acc_ext_i(acc_ext_i), .acc_addr_i(acc_addr_i), .acc_wdata_i(acc_wdata_i),
      .acc_rdata_o(acc_rdata_o), .mem_sel_o(mem_sel_o), .mem_addr_o(mem_addr_o), .step_i(step_i),
      .op_i(op_i), .op_a_i(op_a_i), .op_b_i(op_b_i), .res_i(res_i), .rot_c_i(rot_c_i),
      .wdt_clr_i(wdt_clr_i), .halt_i(halt_i), .wdt_tmo_i(wdt_tmo_i), .tbl_rd_i(tbl_rd_i),
      .tbl_word_i(tbl_word_i), .tbl_addr_o(tbl_addr_o), .bank_o(bank_o), .pc_load_o(pc_load_o),
      .pc_low_o(pc_low_o), .dummy_o(dummy_o));
   csr_exec_model exec (.op_i(op_i), .a_i(op_a_i), .b_i(op_b_i), .cin_i(est[0]), .res_o(res_i),
      .rc_o(rot_c_i), .taddr_i(tbl_addr_o), .word_o(tbl_word_i));

   // free-running 250 MHz clock
   always #2 clk_i = ~clk_i;

   // hang guard: the whole sequence needs only about 150 cycles
   always @(posedge clk_i) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         num_errors++;
         test_done();
      end
   end

   task automatic test_done;
      $display("errors %0d checks %0d", num_errors, check_count);
      if (num_errors == 0 && check_count > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         num_errors++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // one register access; comb outputs sampled mid-cycle, read data after
   task automatic acc(input logic r, input logic w, input logic e, input logic [8:0] ad,
                      input logic [7:0] d);
      @(negedge clk_i);
      acc_rd_i = r;
      acc_wr_i = w;
      acc_ext_i = e;
      acc_addr_i = ad;
      acc_wdata_i = d;
      #1;
      s = mem_sel_o;
      m = mem_addr_o;
      pl = pc_load_o;
      pv = pc_low_o;
      @(negedge clk_i);
      acc_rd_i = 0;
      acc_wr_i = 0;
      acc_ext_i = 0;
      q = acc_rdata_o;
   endtask

   // one-cycle side-band pulse: alu op, system events, table read, pointer step
   task automatic side(input logic [2:0] o, input logic [7:0] x, input logic [7:0] y,
                       input logic [2:0] ev, input logic t, input logic [1:0] st);
      @(negedge clk_i);
      op_i = o;
      op_a_i = x;
      op_b_i = y;
      {halt_i, wdt_tmo_i, wdt_clr_i} = ev;
      tbl_rd_i = t;
      step_i = st;
      @(negedge clk_i);
      op_i = 0;
      {halt_i, wdt_tmo_i, wdt_clr_i} = 3'h0;
      tbl_rd_i = 0;
      step_i = 0;
      q = acc_rdata_o;
   endtask

   // expected status after an alu op, from the flag definitions
   function automatic logic [7:0] nf(input logic [2:0] o, input logic [7:0] x,
                                     input logic [7:0] y, input logic [7:0] old);
      logic [7:0] bb;
      logic ci;
      logic [8:0] s9;
      logic [4:0] s5;
      logic [7:0] s8;
      logic [7:0] f;
      bb = (o == CSR_OP_SUB || o == CSR_OP_SBC) ? ~y : y;
      ci = (o == CSR_OP_SUB) ? 1'b1 : (o == CSR_OP_SBC || o == CSR_OP_ADC) ? old[0] : 1'b0;
      s9 = {1'b0, x} + {1'b0, bb} + 9'(ci);
      s5 = {1'b0, x[3:0]} + {1'b0, bb[3:0]} + 5'(ci);
      s8 = {1'b0, x[6:0]} + {1'b0, bb[6:0]} + 8'(ci);
      f = old;
      if (o == CSR_OP_LOGIC) begin
         f[2] = ((x & y) == 8'h00);
      end else if (o == CSR_OP_ROT) begin
         f[0] = x[7];
      end else begin
         f[0] = s9[8];
         f[1] = s5[4];
         f[2] = (s9[7:0] == 8'h00);
         f[3] = s8[7] ^ s9[8];
         f[7] = f[3] ^ s9[7];
         if (o == CSR_OP_SUB) f[6] = f[2];
         if (o == CSR_OP_SBC) f[6] = old[6] & f[2];
      end
      return f;
   endfunction

   task automatic rd_chk(input logic [7:0] ad, input logic [7:0] exp);
      acc(1, 0, 0, {1'b0, ad}, 8'h00);
      chk(q, exp);
   endtask

   // direct write to a sector-0 register
   task automatic wr(input logic [7:0] ad, input logic [7:0] d);
      acc(0, 1, 0, {1'b0, ad}, d);
   endtask

   initial begin
      logic [2:0] o;
      logic [7:0] x, y, mk;
      repeat (3) @(negedge clk_i);
      rst_n_i = 1;
      // reset state
      chk({bank_o, dummy_o}, 0);
      chk(tbl_addr_o, 0);
      rd_chk(CSR_A_BANK, 8'h00);
      rd_chk(CSR_A_STATUS, 8'h00);
      rd_chk(CSR_A_PTR2H, 8'h00);
      // pointers, then each indirect port: memory address, no storage
      wr(CSR_A_PTR0, 8'h55);
      wr(CSR_A_PTR1L, 8'h40);
      wr(CSR_A_PTR1H, 8'h01);
      wr(CSR_A_PTR2L, 8'h7E);
      for (int i = 0; i < 3; i++) begin
         acc(0, 1, 0, {1'b0, padr[i]}, 8'hAA);
         chk({s, m}, {1'b1, pexp[i]});
         acc(1, 0, 0, {1'b0, padr[i]}, 8'h00);
         chk({s, m, q}, {1'b1, pexp[i], 8'h00});
      end
      rd_chk(CSR_A_PTR0, 8'h55);
      chk(s, 0);
      rd_chk(CSR_A_PTR1L, 8'h40);
      // high byte of pointer two moves port two into sector 1
      wr(CSR_A_PTR2H, 8'h01);
      acc(1, 0, 0, {1'b0, CSR_A_PORT2}, 8'h00);
      chk({s, m}, {1'b1, 9'h17E});
      acc(1, 0, 1, 9'h1F0, 8'h00);
      chk({s, m}, {1'b1, 9'h1F0});
      acc(0, 1, 1, 9'h0F3, 8'h11);
      chk({s, m, pl}, {1'b1, 9'h0F3, 1'b0});
      // pointer zero wraps both ways
      wr(CSR_A_PTR0, 8'hFF);
      side(0, 0, 0, 0, 0, CSR_STEP_INC);
      rd_chk(CSR_A_PTR0, 8'h00);
      side(0, 0, 0, 0, 0, CSR_STEP_DEC);
      rd_chk(CSR_A_PTR0, 8'hFF);
      // bank bit: upper bits not stored
      wr(CSR_A_BANK, 8'hFF);
      chk({bank_o, pl}, 2'b10);
      rd_chk(CSR_A_BANK, 8'h01);
      wr(CSR_A_BANK, 8'hFE);
      chk(bank_o, 0);
      // counter low byte: jump request then a single dummy cycle
      wr(CSR_A_PCLOW, 8'h3C);
      chk({pl, pv, dummy_o}, {1'b1, 8'h3C, 1'b1});
      @(negedge clk_i);
      chk(dummy_o, 0);
      // table read: low byte out, high byte latched
      wr(CSR_A_TBLLOW, 8'h34);
      wr(CSR_A_TBLHIGH, 8'h12);
      chk(tbl_addr_o, 16'h1234);
      side(0, 0, 0, 0, 1, 0);
      chk(q, 8'h12 ^ 8'hC3);
      rd_chk(CSR_A_TBHLATCH, 8'h34 ^ 8'h5A);
      // status writes cannot touch expiry or halted bits
      wr(CSR_A_STATUS, 8'hFF);
      est = 8'hCF;
      rd_chk(CSR_A_STATUS, est);
      side(0, 0, 0, 3'b010, 0, 0);
      est[5] = 1;
      rd_chk(CSR_A_STATUS, est);
      side(0, 0, 0, 3'b100, 0, 0);
      est[5:4] = 2'b01;
      rd_chk(CSR_A_STATUS, est);
      side(0, 0, 0, 3'b010, 0, 0);
      wr(CSR_A_STATUS, 8'h00);
      est = 8'h30;
      rd_chk(CSR_A_STATUS, est);
      side(0, 0, 0, 3'b001, 0, 0);
      est = 8'h00;
      rd_chk(CSR_A_STATUS, est);
      // all events at once: time-out wins the expiry bit, clear wins the halted bit
      side(0, 0, 0, 3'b111, 0, 0);
      rd_chk(CSR_A_STATUS, 8'h20);
      side(0, 0, 0, 3'b001, 0, 0);
      rd_chk(CSR_A_STATUS, est);
      // alu flag table: every op kind, boundary operands
      for (int i = 0; i < 11; i++) begin
         {o, x, y, mk} = tab[i];
         side(o, x, y, 0, 0, 0);
         est = nf(o, x, y, est);
         acc(1, 0, 0, CSR_A_STATUS, 8'h00);
         chk(q & mk, est & mk);
      end
      // mid-run reset: high pointer bytes, bank, table pointers and status fall back
      wr(CSR_A_BANK, 8'h01);
      rst_n_i = 0;
      repeat (3) @(negedge clk_i);
      rst_n_i = 1;
      chk({bank_o, dummy_o, tbl_addr_o}, 0);
      rd_chk(CSR_A_PTR1H, 8'h00);
      rd_chk(CSR_A_PTR2H, 8'h00);
      rd_chk(CSR_A_STATUS, 8'h00);
      test_done();
   end
endmodule
